/* File: rtl/i2c_port_pkg.sv */
// Constants and types shared by the two-wire slave register port.
// Assumes 8-bit registers behind an 8-bit register pointer.
package i2c_port_pkg;

  // Bits in one serial byte, and the bit count that marks a full byte
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_STEP = 4'h1;

  // Seven-bit slave address with the strap low; the strap sets bit 0
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h2C;

  // Register pointer reset value and auto-increment step
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // Direction bit value that asks for a read
  localparam logic DIR_READ = 1'b1;

  // Bit positions inside the link-side synchroniser vector
  localparam int SYN_SCL = 4;
  localparam int SYN_SDA = 3;
  localparam int SYN_STRAP = 2;
  localparam int SYN_RST = 1;
  localparam int SYN_RDACK = 0;

  // Bit positions inside the core-side synchroniser vector
  localparam int CSY_WR = 3;
  localparam int CSY_RD = 2;
  localparam int CSY_BUSY = 1;
  localparam int CSY_ABORT = 0;

  // Link phases; idle must stay first so an all-zero reset lands in it
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ADDR_ACK,
    LINK_RECV,
    LINK_RECV_ACK,
    LINK_SEND,
    LINK_SEND_ACK
  } linkState_t;

endpackage : i2c_port_pkg

/* File: rtl/sync_two_flop.sv */
// Two flip-flop level synchroniser for a vector of independent bits.
// Assumes each bit is a level or a toggle; multi-bit words need a handshake.
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // No reset: the reset itself passes through one of these
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } syncState_t;

  syncState_t sync_r;
  syncState_t sync_nxt;

  if (WIDTH < 1) begin : gBadWidth
    $error("sync_two_flop needs WIDTH of at least one");
  end

  // First stage feeds only the second stage
  always_comb begin
    sync_nxt.meta = d;
    sync_nxt.stable = sync_r.meta;
  end

  always_ff @(posedge clock) begin
    sync_r <= sync_nxt;
  end

  assign q = sync_r.stable;

endmodule : sync_two_flop

/* File: rtl/i2c_slave_register_port.sv */
// Two-wire serial slave port that reads and writes 8-bit internal registers.
// Assumes linkClock runs freely and oversamples SCL by at least 8x per phase;
// the register file sits on clock and answers regRdData one cycle after regAddr.
`timescale 1ns/1ps
module i2c_slave_register_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic linkClock,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSel,
  output logic regWrEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  output logic busy,
  output logic abortPulse
);
  import i2c_port_pkg::*;

  // Link-domain state, all on linkClock
  typedef struct packed {
    linkState_t state;
    logic [3:0] bitCnt;     // Bits seen in the current byte
    logic [7:0] shift;      // Incoming byte
    logic [7:0] txByte;     // Outgoing byte, bit 7 on the wire
    logic [7:0] ptr;        // Register pointer
    logic gotPtr;           // Pointer byte already taken in this write
    logic isRead;
    logic mAck;             // Master acknowledge seen on a read byte
    logic sclPrev;
    logic sdaPrev;
    logic sdaOe;
    logic sdaOut;
    logic busy;
    logic [7:0] wrAddr;     // Held stable while wrTgl crosses
    logic [7:0] wrData;
    logic wrTgl;
    logic [7:0] rdAddr;     // Held stable while rdReqTgl crosses
    logic rdReqTgl;
    logic rdAckSeen;
    logic [7:0] rdByte;     // Prefetched register byte
    logic abortTgl;
  } link_t;

  // Core-domain state, all on clock
  typedef struct packed {
    logic wrSeen;
    logic rdSeen;
    logic busySeen;
    logic abortSeen;
    logic rdPend;
    logic regWrEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] rdData;     // Held stable while rdAckTgl crosses
    logic rdAckTgl;
    logic busy;
    logic abortPulse;
  } core_t;

  link_t lnk_r;
  link_t lnk_nxt;
  core_t core_r;
  core_t core_nxt;

  logic [4:0] linkSync;
  logic [3:0] coreSync;
  logic sclS;
  logic sdaS;
  logic strapS;
  logic linkRst;
  logic rdAckS;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic [6:0] ownAddr;

  // Open-drain drive: enable pulls the line low, so a one means release
  function automatic logic drvEnable(input logic level);
    drvEnable = ~level;
  endfunction : drvEnable

  // A start or stop sits in the high phase after one counted SCL rise,
  // so a count of one still marks a byte boundary, not a cut byte
  function automatic logic atByteEdge(input logic [3:0] cnt);
    atByteEdge = (cnt == BIT_CNT_ZERO) || (cnt == BIT_CNT_STEP);
  endfunction : atByteEdge

  // Pins, reset and the read answer toggle enter the link domain here
  sync_two_flop #(
    .WIDTH(5)
  ) uLinkSync (
    .clock(linkClock),
    .d({sclIn, sdaIn, addrSel, srst, core_r.rdAckTgl}),
    .q(linkSync)
  );

  // Link toggles and busy level enter the core domain here
  sync_two_flop #(
    .WIDTH(4)
  ) uCoreSync (
    .clock(clock),
    .d({lnk_r.wrTgl, lnk_r.rdReqTgl, lnk_r.busy, lnk_r.abortTgl}),
    .q(coreSync)
  );

  assign sclS = linkSync[SYN_SCL];
  assign sdaS = linkSync[SYN_SDA];
  assign strapS = linkSync[SYN_STRAP];
  assign linkRst = linkSync[SYN_RST];
  assign rdAckS = linkSync[SYN_RDACK];

  // Strap picks the low address bit
  assign ownAddr = {SLAVE_ADDR_BASE[6:1], strapS};

  // Edge and condition detection on the synchronised lines
  assign sclRise = sclS & ~lnk_r.sclPrev;
  assign sclFall = ~sclS & lnk_r.sclPrev;
  assign startEv = sclS & lnk_r.sclPrev & lnk_r.sdaPrev & ~sdaS;
  assign stopEv = sclS & lnk_r.sclPrev & ~lnk_r.sdaPrev & sdaS;

  // Link state machine; SCL is only ever read, never driven
  always_comb begin
    lnk_nxt = lnk_r;
    lnk_nxt.sclPrev = sclS;
    lnk_nxt.sdaPrev = sdaS;
    lnk_nxt.sdaOut = 1'b0;

    // Capture a returned register byte once its answer toggle arrives
    if (rdAckS != lnk_r.rdAckSeen) begin
      lnk_nxt.rdAckSeen = rdAckS;
      lnk_nxt.rdByte = core_r.rdData;
    end

    if (stopEv) begin
      // Stop frees the bus from any phase
      lnk_nxt.state = LINK_IDLE;
      lnk_nxt.sdaOe = 1'b0;
      lnk_nxt.bitCnt = BIT_CNT_ZERO;
      if (!atByteEdge(lnk_r.bitCnt)) begin
        lnk_nxt.abortTgl = ~lnk_r.abortTgl;
      end
    end else if (startEv) begin
      lnk_nxt.sdaOe = 1'b0;
      lnk_nxt.bitCnt = BIT_CNT_ZERO;
      if (lnk_r.state == LINK_IDLE || atByteEdge(lnk_r.bitCnt)) begin
        // First or repeated start opens an address phase
        lnk_nxt.state = LINK_ADDR;
      end else begin
        // A start inside a byte is an illegal transition; drop everything
        lnk_nxt.state = LINK_IDLE;
        lnk_nxt.abortTgl = ~lnk_r.abortTgl;
      end
    end else begin
      unique case (lnk_r.state)
        LINK_IDLE: begin
          // Nothing happens until the master makes a start
          lnk_nxt.sdaOe = 1'b0;
        end

        LINK_ADDR, LINK_RECV: begin
          if (sclRise && lnk_r.bitCnt != BIT_CNT_FULL) begin
            // Sample while SCL is high, most significant bit first
            lnk_nxt.shift = {lnk_r.shift[6:0], sdaS};
            lnk_nxt.bitCnt = lnk_r.bitCnt + BIT_CNT_STEP;
          end else if (sclFall && lnk_r.bitCnt == BIT_CNT_FULL) begin
            lnk_nxt.bitCnt = BIT_CNT_ZERO;
            if (lnk_r.state == LINK_ADDR) begin
              // Seven address bits then the direction bit
              if (lnk_r.shift[7:1] == ownAddr) begin
                lnk_nxt.sdaOe = 1'b1;
                lnk_nxt.isRead = (lnk_r.shift[0] == DIR_READ);
                lnk_nxt.state = LINK_ADDR_ACK;
                if (lnk_r.shift[0] == DIR_READ) begin
                  // Fetch the pointed byte during the acknowledge pulse
                  lnk_nxt.rdAddr = lnk_r.ptr;
                  lnk_nxt.rdReqTgl = ~lnk_r.rdReqTgl;
                end
              end else begin
                // Not ours: stay off the line until the next start
                lnk_nxt.state = LINK_IDLE;
              end
            end else begin
              // Pointer and data bytes are always acknowledged
              lnk_nxt.sdaOe = 1'b1;
              lnk_nxt.state = LINK_RECV_ACK;
            end
          end
        end

        LINK_ADDR_ACK: begin
          if (sclFall) begin
            // Acknowledge held through the whole high phase, released on the fall
            lnk_nxt.sdaOe = 1'b0;
            if (lnk_r.isRead) begin
              // Transmit: first bit goes out while SCL is low
              lnk_nxt.state = LINK_SEND;
              lnk_nxt.txByte = lnk_r.rdByte;
              lnk_nxt.sdaOe = drvEnable(lnk_r.rdByte[7]);
              lnk_nxt.rdAddr = lnk_r.ptr + PTR_STEP;
              lnk_nxt.rdReqTgl = ~lnk_r.rdReqTgl;
            end else begin
              lnk_nxt.state = LINK_RECV;
              lnk_nxt.gotPtr = 1'b0;
            end
          end
        end

        LINK_RECV_ACK: begin
          if (sclFall) begin
            lnk_nxt.sdaOe = 1'b0;
            lnk_nxt.state = LINK_RECV;
            if (!lnk_r.gotPtr) begin
              // First byte after a write address is the register pointer
              lnk_nxt.ptr = lnk_r.shift;
              lnk_nxt.gotPtr = 1'b1;
            end else begin
              // Commit only once the acknowledge pulse has ended
              lnk_nxt.wrAddr = lnk_r.ptr;
              lnk_nxt.wrData = lnk_r.shift;
              lnk_nxt.wrTgl = ~lnk_r.wrTgl;
              lnk_nxt.ptr = lnk_r.ptr + PTR_STEP;
            end
          end
        end

        LINK_SEND: begin
          if (sclRise) begin
            lnk_nxt.bitCnt = lnk_r.bitCnt + BIT_CNT_STEP;
          end else if (sclFall) begin
            if (lnk_r.bitCnt == BIT_CNT_FULL) begin
              // Let go for the master's acknowledge
              lnk_nxt.sdaOe = 1'b0;
              lnk_nxt.bitCnt = BIT_CNT_ZERO;
              lnk_nxt.mAck = 1'b0;
              lnk_nxt.state = LINK_SEND_ACK;
            end else begin
              // Next bit changes only while SCL is low
              lnk_nxt.txByte = {lnk_r.txByte[6:0], 1'b0};
              lnk_nxt.sdaOe = drvEnable(lnk_r.txByte[6]);
            end
          end
        end

        LINK_SEND_ACK: begin
          if (sclRise) begin
            lnk_nxt.mAck = ~sdaS;
          end else if (sclFall) begin
            if (lnk_r.mAck) begin
              // Acknowledged: step on and send the prefetched byte
              lnk_nxt.ptr = lnk_r.ptr + PTR_STEP;
              lnk_nxt.txByte = lnk_r.rdByte;
              lnk_nxt.sdaOe = drvEnable(lnk_r.rdByte[7]);
              lnk_nxt.rdAddr = lnk_r.ptr + PTR_STEP + PTR_STEP;
              lnk_nxt.rdReqTgl = ~lnk_r.rdReqTgl;
              lnk_nxt.state = LINK_SEND;
            end else begin
              // Not acknowledged: stay released and go idle until the next start or stop
              lnk_nxt.sdaOe = 1'b0;
              lnk_nxt.state = LINK_IDLE;
            end
          end
        end
        default: begin
          // An unused state code falls back to idle, off the line
          lnk_nxt.state = LINK_IDLE;
          lnk_nxt.sdaOe = 1'b0;
        end
      endcase
    end

    // Busy spans from start to stop, a foreign address, a master not-acknowledge or a start inside a byte; the device never starts one itself
    lnk_nxt.busy = (lnk_nxt.state != LINK_IDLE);
  end

  // Link registers; idle is the all-zero state
  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // Core side: turns link toggles into register strobes and fetches
  always_comb begin
    core_nxt = core_r;
    core_nxt.regWrEn = 1'b0;
    core_nxt.abortPulse = 1'b0;
    core_nxt.busySeen = coreSync[CSY_BUSY];
    core_nxt.busy = core_r.busySeen;
    core_nxt.abortSeen = coreSync[CSY_ABORT];
    core_nxt.wrSeen = coreSync[CSY_WR];

    // Register file answers one cycle after the address settles
    if (core_r.rdPend) begin
      core_nxt.rdData = regRdData;
      core_nxt.rdAckTgl = ~core_r.rdAckTgl;
      core_nxt.rdPend = 1'b0;
    end

    // Write data is stable in the link flops when its toggle lands
    if (coreSync[CSY_WR] != core_r.wrSeen) begin
      core_nxt.regAddr = lnk_r.wrAddr;
      core_nxt.regWrData = lnk_r.wrData;
      core_nxt.regWrEn = 1'b1;
    end else if (coreSync[CSY_RD] != core_r.rdSeen && !core_r.rdPend) begin
      // A read waits a cycle if a write or earlier read holds the address
      core_nxt.regAddr = lnk_r.rdAddr;
      core_nxt.rdSeen = coreSync[CSY_RD];
      core_nxt.rdPend = 1'b1;
    end

    if (coreSync[CSY_ABORT] != core_r.abortSeen) begin
      core_nxt.abortPulse = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  // Every output comes straight from a flop
  assign sdaOut = lnk_r.sdaOut;
  assign sdaOe = lnk_r.sdaOe;
  assign regWrEn = core_r.regWrEn;
  assign regAddr = core_r.regAddr;
  assign regWrData = core_r.regWrData;
  assign busy = core_r.busy;
  assign abortPulse = core_r.abortPulse;

endmodule : i2c_slave_register_port

/* File: tb/i2c_port_checker.sv */
// Assertions on the ports of the two-wire slave register port.
// Assumes a bind to the port top; link side is clocked by linkClock.
`timescale 1ns/1ps
module i2c_port_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic linkClock,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic regWrEn,
  input wire logic busy,
  input wire logic abortPulse
);
  // Link side: open-drain pin, and SDA only moves while SCL is low
  property p_sdaLowOnly;
    @(posedge linkClock) disable iff (srst) sdaOut == 1'b0;
  endproperty
  a_sdaLowOnly: assert property (p_sdaLowOnly) else $error("sdaOut high");
  property p_oeMovesLow;
    @(posedge linkClock) disable iff (srst) $changed(sdaOe) |-> !sclIn;
  endproperty
  a_oeMovesLow: assert property (p_oeMovesLow) else $error("sdaOe moved, SCL high");
  // Core side: writes are single pulses inside a transaction
  property p_wrPulse;
    @(posedge clock) disable iff (srst) regWrEn |=> !regWrEn;
  endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("regWrEn too long");
  property p_wrInBusy;
    @(posedge clock) disable iff (srst) regWrEn |-> busy;
  endproperty
  a_wrInBusy: assert property (p_wrInBusy) else $error("write while idle");
  // Abort is a pulse and drops the transaction within a few cycles
  property p_abortPulse;
    @(posedge clock) disable iff (srst) abortPulse |=> !abortPulse;
  endproperty
  a_abortPulse: assert property (p_abortPulse) else $error("abortPulse too long");
  property p_abortIdle;
    @(posedge clock) disable iff (srst) abortPulse |-> ##[0:16] !busy;
  endproperty
  a_abortIdle: assert property (p_abortIdle) else $error("busy after abort");
  // Busy starts only on a start condition, still held by the master
  property p_busyStart;
    @(posedge clock) disable iff (srst) $rose(busy) |-> sclIn && !sdaIn;
  endproperty
  a_busyStart: assert property (p_busyStart) else $error("busy without start");
  property p_oeInBusy;
    @(posedge clock) disable iff (srst) sdaOe |-> busy;
  endproperty
  a_oeInBusy: assert property (p_oeInBusy) else $error("SDA pulled while idle");
endmodule : i2c_port_checker

bind i2c_slave_register_port i2c_port_checker i_i2c_port_checker (
  .clock, .srst, .linkClock, .sclIn, .sdaIn, .sdaOut, .sdaOe, .regWrEn, .busy, .abortPulse
);

/* File: tb/i2c_master_model.sv */
// Behavioural two-wire bus master on the far side of the port.
// Assumes the bench resolves SDA from sdaLow and the slave's enable.
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clock,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  localparam int HOLD = 52; // Phase above 16 link periods, room for the fetch
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // One bus phase, stepped on the falling core clock
  task automatic hold();
    repeat (HOLD) @(negedge clock);
  endtask : hold
  // SDA set while SCL is low, sampled at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    hold();
    sdaLow = ~b;
    hold();
    scl = 1'b1;
    hold();
    r = sdaWire;
    scl = 1'b0;
  endtask : bitx
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    hold();
    sdaLow = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sdaLow = 1'b1;
    hold();
    scl = 1'b0;
  endtask : start
  // Stop: SDA rises while SCL is high
  task automatic stop();
    hold();
    sdaLow = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sdaLow = 1'b0;
    hold();
  endtask : stop
  // Byte MSB first then the ninth pulse; ackOut high leaves SDA released
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], r);
      rx[i] = r;
    end
    bitx(ackOut, r);
    acked = ~r;
  endtask : xfer
endmodule : i2c_master_model

/* File: tb/i2c_slave_register_port_bench.sv */
// Self-checking bench for the two-wire slave register port.
// Assumes the master model above and a register array kept here.
`timescale 1ns/1ps
module i2c_slave_register_port_bench;
  logic clock = 1'b0;
  logic linkClock = 1'b0;
  logic srst = 1'b1;
  logic addrSel = 1'b0;
  int abortCount = 0;
  logic scl, sdaLow, sdaWire, sdaOut, sdaOe, regWrEn, busy, abortPulse;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [7:0] regs [256];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  // Core clock 25 ns; link clock 80 ns with its own phase
  always #12.5 clock = ~clock;
  initial begin
    #7;
    forever #40 linkClock = ~linkClock;
  end
  // Pull-up on SDA unless either party pulls it low
  assign sdaWire = ~(sdaLow | sdaOe);
  // Register file: combinational read, write on the pulse
  assign regRdData = regs[regAddr];
  always @(posedge clock) if (regWrEn) regs[regAddr] <= regWrData;
  always @(posedge clock) if (abortPulse) abortCount <= abortCount + 1;

  i2c_slave_register_port i_i2c_slave_register_port (
    .clock, .srst, .linkClock, .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOe, .addrSel,
    .regWrEn, .regAddr, .regWrData, .regRdData, .busy, .abortPulse
  );
  i2c_master_model i_i2c_master_model (.clock, .sdaWire, .scl, .sdaLow);

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Master sends a byte and expects the slave to acknowledge
  task automatic wb(input logic [7:0] b, input string what);
    logic [7:0] rx;
    logic ak;
    i_i2c_master_model.xfer(b, 1'b1, rx, ak);
    chk(what, {7'h00, ak}, 8'h01);
  endtask : wb
  // Master reads a byte, then acknowledges or not
  task automatic rb(input logic [7:0] exp, input logic nack, input string what);
    logic [7:0] rx;
    logic ak;
    i_i2c_master_model.xfer(8'hFF, nack, rx, ak);
    chk(what, rx, exp);
  endtask : rb
  task automatic s_write();
    i_i2c_master_model.start();
    chk("busy", {7'h00, busy}, 8'h01);
    wb(8'h58, "write address");
    wb(8'h10, "pointer");
    wb(8'hA5, "data 0");
    wb(8'h3C, "data 1");
    i_i2c_master_model.stop();
    repeat (40) @(negedge clock);
    chk("reg 10", regs[8'h10], 8'hA5);
    chk("reg 11", regs[8'h11], 8'h3C);
    chk("busy", {7'h00, busy}, 8'h00);
  endtask : s_write
  task automatic s_read();
    i_i2c_master_model.start();
    wb(8'h58, "write address");
    wb(8'h10, "pointer");
    i_i2c_master_model.start();
    wb(8'h59, "read address");
    rb(8'hA5, 1'b0, "read 0");
    rb(8'h3C, 1'b1, "read 1");
    // Give a runaway next byte time to reach the pin before looking
    repeat (20) @(negedge clock);
    chk("sdaOe", {7'h00, sdaOe}, 8'h00);
    i_i2c_master_model.stop();
  endtask : s_read
  // Each strap level: foreign address ignored, own address written
  task automatic s_strap();
    logic [7:0] rx;
    logic ak;
    for (int s = 0; s < 2; s++) begin
      addrSel = s[0];
      i_i2c_master_model.start();
      i_i2c_master_model.xfer(s ? 8'h58 : 8'h5A, 1'b1, rx, ak);
      chk("foreign ack", {7'h00, ak}, 8'h00);
      i_i2c_master_model.stop();
      i_i2c_master_model.start();
      wb(s ? 8'h5A : 8'h58, "own address");
      wb(8'h20 + s[7:0], "pointer");
      wb(8'h66, "data");
      i_i2c_master_model.stop();
      chk("strap reg", regs[8'h20 + s[7:0]], 8'h66);
    end
    addrSel = 1'b0;
  endtask : s_strap
  // Stop or start in mid-byte drops the transfer and leaves the register alone
  task automatic s_abort();
    logic r;
    logic [7:0] rx;
    logic ak;
    chk("no abort", 8'(abortCount), 8'h00);
    i_i2c_master_model.start();
    wb(8'h58, "write address");
    wb(8'h30, "pointer");
    for (int i = 0; i < 4; i++) i_i2c_master_model.bitx(1'b0, r);
    i_i2c_master_model.stop();
    repeat (40) @(negedge clock);
    chk("abort", 8'(abortCount), 8'h01);
    chk("reg 30", regs[8'h30], 8'h30);
    chk("busy", {7'h00, busy}, 8'h00);
    // A start after three bits is illegal too and opens no address phase
    i_i2c_master_model.start();
    wb(8'h58, "write address");
    wb(8'h31, "pointer");
    for (int i = 0; i < 3; i++) i_i2c_master_model.bitx(1'b1, r);
    i_i2c_master_model.start();
    i_i2c_master_model.xfer(8'h58, 1'b1, rx, ak);
    chk("ack after abort", {7'h00, ak}, 8'h00);
    i_i2c_master_model.stop();
    repeat (40) @(negedge clock);
    chk("abort", 8'(abortCount), 8'h02);
    chk("reg 31", regs[8'h31], 8'h31);
    chk("busy", {7'h00, busy}, 8'h00);
  endtask : s_abort
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // Hang guard, about twice the expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 75000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) regs[i] = i[7:0];
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (24) @(negedge clock);
    s_write();
    s_read();
    s_strap();
    s_abort();
    wrap_up();
  end
endmodule : i2c_slave_register_port_bench
